// >>> shared/walker_link_pkg.sv
// Package: encodings and timing for the page walker to client link
package walker_link_pkg;

    localparam int NUM_CLIENTS   = 4;
    localparam int CLIENT_ID_W   = 2;
    localparam int VA_W          = 36;
    localparam int PA_W          = 27;
    localparam int TRACK_W       = 8;
    localparam int BEAT_CYCLES   = 4;
    localparam int CLIENT_CREDITS = 2;

    localparam logic [1:0] RSP_OP_PAGE      = 2'h0;
    localparam logic [1:0] RSP_OP_RESERVED  = 2'h1;
    localparam logic [1:0] RSP_OP_INV_START = 2'h2;
    localparam logic [1:0] RSP_OP_INV_END   = 2'h3;

    localparam logic REQ_OP_PAGE = 1'b0;
    localparam logic REQ_OP_ACK  = 1'b1;

    localparam logic [1:0] FAULT_NONE        = 2'h0;
    localparam logic [1:0] FAULT_NOT_PRESENT = 2'h1;
    localparam logic [1:0] FAULT_PRIVILEGE   = 2'h2;
    localparam logic [1:0] FAULT_WRITE       = 2'h3;

    localparam logic [2:0] MTYPE_UC = 3'h0;
    localparam logic [2:0] MTYPE_WC = 3'h1;
    localparam logic [2:0] MTYPE_WT = 3'h4;
    localparam logic [2:0] MTYPE_WP = 3'h5;
    localparam logic [2:0] MTYPE_WB = 3'h6;

    localparam logic [1:0] L3_CTL_UC = 2'h0;
    localparam logic [1:0] L3_CTL_WC = 2'h1;
    localparam logic [1:0] L3_CTL_WT = 2'h2;
    localparam logic [1:0] L3_CTL_WB = 2'h3;

    // /05 mapping, applied at the client end only
    function automatic logic [1:0] l3_ctl(input logic [2:0] mtype,
                                          input logic       wr);
        logic [1:0] c;
        c = L3_CTL_UC;
        unique case (mtype)
            MTYPE_WC: c = L3_CTL_WC;
            MTYPE_WT: c = L3_CTL_WT;
            MTYPE_WP: c = wr ? L3_CTL_WC : L3_CTL_WB;
            MTYPE_WB: c = L3_CTL_WB;
            default:  c = L3_CTL_UC;
        endcase
        return c;
    endfunction
endpackage

// >>> shared/walker_link_if.sv
// Interface: serialised request and broadcast response buses
`timescale 1ns/1ps
interface walker_link_if;
    import walker_link_pkg::*;
    // Request: one beat per cycle, message spans BEAT_CYCLES beats
    logic                   req_valid;
    logic                   req_op;
    logic [CLIENT_ID_W-1:0] req_client;
    logic                   req_wr;
    logic                   req_faultable;
    logic [TRACK_W-1:0]     req_track;
    logic [VA_W-1:0]        req_va;
    // Response: broadcast, first beat marks start of message
    logic                   rsp_valid;
    logic [1:0]             rsp_op;
    logic [CLIENT_ID_W-1:0] rsp_client;
    logic                   rsp_wr;
    logic                   rsp_dirty;
    logic [1:0]             rsp_fault;
    logic [2:0]             rsp_mtype;
    logic [TRACK_W-1:0]     rsp_track;
    logic [PA_W-1:0]        rsp_pa;
    modport walker (input req_valid, req_op, req_client, req_wr,
                    req_faultable, req_track, req_va,
                    output rsp_valid, rsp_op, rsp_client, rsp_wr,
                    rsp_dirty, rsp_fault, rsp_mtype, rsp_track, rsp_pa);
    modport client (output req_valid, req_op, req_client, req_wr,
                    req_faultable, req_track, req_va,
                    input rsp_valid, rsp_op, rsp_client, rsp_wr,
                    rsp_dirty, rsp_fault, rsp_mtype, rsp_track, rsp_pa);
endinterface

// >>> hw/page_walker_end.sv
// Page walker end: response serialiser and invalidation sequencer
`timescale 1ns/1ps
module page_walker_end
    import walker_link_pkg::*;
#(
    parameter int N_CLIENTS = NUM_CLIENTS
) (
    input  wire logic                   clk_sys,
    input  wire logic                   reset_n,
    input  wire logic                   clk_en,
    walker_link_if.walker               link,
    // Walk lookup side
    output logic                        walk_req_valid,
    output logic [CLIENT_ID_W-1:0]      walk_req_client,
    output logic                        walk_req_wr,
    output logic                        walk_req_faultable,
    output logic [TRACK_W-1:0]          walk_req_track,
    output logic [VA_W-1:0]             walk_req_va,
    input  wire logic                   walk_rsp_valid,
    output logic                        walk_rsp_ready,
    input  wire logic [CLIENT_ID_W-1:0] walk_rsp_client,
    input  wire logic                   walk_rsp_wr,
    input  wire logic                   walk_rsp_dirty,
    input  wire logic [1:0]             walk_rsp_fault,
    input  wire logic [2:0]             walk_rsp_mtype,
    input  wire logic [TRACK_W-1:0]     walk_rsp_track,
    input  wire logic [PA_W-1:0]        walk_rsp_pa,
    input  wire logic                   inv_event,
    output logic                        inv_busy
);
    // Ack flags are indexed by client id, beat counter is two bits
    if (N_CLIENTS < 1 || N_CLIENTS > (1 << CLIENT_ID_W)) begin
        $error("page_walker_end: bad client count");
    end
    if (BEAT_CYCLES < 2 || BEAT_CYCLES > 4) begin
        $error("page_walker_end: beat count exceeds counter");
    end

    typedef enum logic [1:0] {W_IDLE, W_START, W_WAIT, W_END} wstate_e;

    typedef struct packed {
        wstate_e                  st;
        logic [1:0]               beat;
        logic                     busy;
        logic                     inv_pend;
        logic [N_CLIENTS-1:0]     acked;
        logic                     rsp_valid;
        logic [1:0]               rsp_op;
        logic [CLIENT_ID_W-1:0]   rsp_client;
        logic                     rsp_wr;
        logic                     rsp_dirty;
        logic [1:0]               rsp_fault;
        logic [2:0]               rsp_mtype;
        logic [TRACK_W-1:0]       rsp_track;
        logic [PA_W-1:0]          rsp_pa;
        logic                     wreq_valid;
        logic [CLIENT_ID_W-1:0]   wreq_client;
        logic                     wreq_wr;
        logic                     wreq_flt;
        logic [TRACK_W-1:0]       wreq_track;
        logic [VA_W-1:0]          wreq_va;
    } wstate_s;

    wstate_s              s_q;
    wstate_s              s_d;
    logic                 ack_sel;
    logic                 launch;
    logic                 page_take;
    logic                 rsp_take;
    logic [N_CLIENTS-1:0] ack_hit;

    // Acks are accepted at the first beat of a request message
    assign ack_sel = link.req_valid && link.req_op == REQ_OP_ACK;
    // Response slot free once previous message finished its beats
    assign launch  = !s_q.busy;
    assign walk_rsp_ready = launch && s_q.st == W_IDLE && !s_q.inv_pend
                            && !inv_event;
    // Page requests reach the walk only while idle with no invalidation pending
    assign page_take = link.req_valid && link.req_op == REQ_OP_PAGE
                       && s_q.st == W_IDLE && !s_q.inv_pend;
    assign rsp_take  = walk_rsp_ready && walk_rsp_valid;

    // One acknowledge flag per client, set by its own ack message
    for (genvar i = 0; i < N_CLIENTS; i++) begin : g_ack
        assign ack_hit[i] = ack_sel
                            && int'(link.req_client) == i;
    end

    always_comb begin
        s_d = s_q;
        s_d.wreq_valid = 1'b0;
        if (s_q.busy) begin
            s_d.beat = s_q.beat + 2'h1;
            if (s_q.beat == 2'(BEAT_CYCLES - 1)) begin
                s_d.busy      = 1'b0;
                s_d.rsp_valid = 1'b0;
            end
        end
        if (inv_event)
            s_d.inv_pend = 1'b1;
        if (page_take) begin
            s_d.wreq_valid  = 1'b1;
            s_d.wreq_client = link.req_client;
            s_d.wreq_wr     = link.req_wr;
            s_d.wreq_flt    = link.req_faultable;
            s_d.wreq_track  = link.req_track;
            s_d.wreq_va     = link.req_va;
        end
        unique case (s_q.st)
            W_IDLE: begin
                if (launch && s_q.inv_pend) begin
                    s_d.st = W_START;
                end else if (rsp_take) begin
                    s_d.busy       = 1'b1;
                    s_d.beat       = 2'h0;
                    s_d.rsp_valid  = 1'b1;
                    s_d.rsp_op     = RSP_OP_PAGE;
                    s_d.rsp_client = walk_rsp_client;
                    s_d.rsp_wr     = walk_rsp_wr;
                    s_d.rsp_dirty  = walk_rsp_dirty;
                    s_d.rsp_fault  = walk_rsp_fault;
                    s_d.rsp_mtype  = walk_rsp_mtype;
                    s_d.rsp_track  = walk_rsp_track;
                    s_d.rsp_pa     = walk_rsp_pa;
                end
            end
            W_START: begin
                s_d.busy      = 1'b1;
                s_d.beat      = 2'h0;
                s_d.rsp_valid = 1'b1;
                s_d.rsp_op    = RSP_OP_INV_START;
                s_d.acked     = '0;
                s_d.inv_pend  = inv_event;
                s_d.st        = W_WAIT;
            end
            W_WAIT: begin
                if (&s_q.acked && launch)
                    s_d.st = W_END;
            end
            W_END: begin
                s_d.busy      = 1'b1;
                s_d.beat      = 2'h0;
                s_d.rsp_valid = 1'b1;
                s_d.rsp_op    = RSP_OP_INV_END;
                s_d.st        = W_IDLE;
            end
        endcase
        if (s_q.st == W_WAIT)
            s_d.acked = s_d.acked | ack_hit;
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '0;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    // Fields held for all four beats of a message, rsp_valid on the first beat only
    assign link.rsp_valid  = s_q.rsp_valid && s_q.beat == 2'h0;
    assign link.rsp_op     = s_q.rsp_op;
    assign link.rsp_client = s_q.rsp_client;
    assign link.rsp_wr     = s_q.rsp_wr;
    assign link.rsp_dirty  = s_q.rsp_dirty;
    assign link.rsp_fault  = s_q.rsp_fault;
    assign link.rsp_mtype  = s_q.rsp_mtype;
    assign link.rsp_track  = s_q.rsp_track;
    assign link.rsp_pa     = s_q.rsp_pa;

    assign walk_req_valid     = s_q.wreq_valid;
    assign walk_req_client    = s_q.wreq_client;
    assign walk_req_wr        = s_q.wreq_wr;
    assign walk_req_faultable = s_q.wreq_flt;
    assign walk_req_track     = s_q.wreq_track;
    assign walk_req_va        = s_q.wreq_va;
    assign inv_busy           = s_q.st != W_IDLE || s_q.inv_pend;
endmodule

// >>> hw/data_port_client_end.sv
// Data port client end: mini-TLB owner, credits and invalidation drain
`timescale 1ns/1ps
module data_port_client_end
    import walker_link_pkg::*;
#(
    parameter logic [CLIENT_ID_W-1:0] CLIENT_ID = '0
) (
    input  wire logic               clk_sys,
    input  wire logic               reset_n,
    input  wire logic               clk_en,
    walker_link_if.client           link,
    input  wire logic               tr_req_valid,
    output logic                    tr_req_ready,
    input  wire logic               tr_req_wr,
    input  wire logic               tr_req_faultable,
    input  wire logic [TRACK_W-1:0] tr_req_track,
    input  wire logic [VA_W-1:0]    tr_req_va,
    output logic                    tr_rsp_valid,
    output logic [TRACK_W-1:0]      tr_rsp_track,
    output logic [PA_W-1:0]         tr_rsp_pa,
    output logic [1:0]              tr_rsp_fault,
    output logic                    tr_rsp_dirty,
    output logic [1:0]              tr_rsp_l3_ctl,
    output logic                    tlb_flush,
    input  wire logic               accesses_drained
);
    typedef enum logic [1:0] {C_RUN, C_DRAIN, C_WAIT_END} cstate_e;

    typedef struct packed {
        cstate_e            st;
        logic [1:0]         credits;
        logic [1:0]         beat;
        logic               busy;
        logic               req_op;
        logic               req_wr;
        logic               req_flt;
        logic [TRACK_W-1:0] req_track;
        logic [VA_W-1:0]    req_va;
        logic               rsp_valid;
        logic [TRACK_W-1:0] rsp_track;
        logic [PA_W-1:0]    rsp_pa;
        logic [1:0]         rsp_fault;
        logic               rsp_dirty;
        logic [1:0]         rsp_l3;
        logic               flush;
    } cstate_s;

    cstate_s s_q;
    cstate_s s_d;
    logic    mine;

    assign mine = link.rsp_valid && link.rsp_op == RSP_OP_PAGE
                  && link.rsp_client == CLIENT_ID;
    assign tr_req_ready = s_q.st == C_RUN && !s_q.busy
                          && s_q.credits != 2'h0;

    always_comb begin
        s_d = s_q;
        s_d.rsp_valid = 1'b0;
        s_d.flush     = 1'b0;
        if (s_q.busy) begin
            s_d.beat = s_q.beat + 2'h1;
            if (s_q.beat == 2'(BEAT_CYCLES - 1))
                s_d.busy = 1'b0;
        end
        if (tr_req_valid && tr_req_ready) begin
            s_d.busy      = 1'b1;
            s_d.beat      = 2'h0;
            s_d.req_op    = REQ_OP_PAGE;
            s_d.req_wr    = tr_req_wr;
            s_d.req_flt   = tr_req_faultable;
            s_d.req_track = tr_req_track;
            s_d.req_va    = tr_req_va;
            s_d.credits   = s_d.credits - 2'h1;
        end
        if (mine) begin
            s_d.credits   = s_d.credits + 2'h1;
            s_d.rsp_valid = 1'b1;
            s_d.rsp_track = link.rsp_track;
            s_d.rsp_pa    = link.rsp_pa;
            s_d.rsp_fault = link.rsp_fault;
            s_d.rsp_dirty = link.rsp_dirty;
            s_d.rsp_l3    = l3_ctl(link.rsp_mtype,
                                   link.rsp_wr);
        end
        unique case (s_q.st)
            C_RUN: begin
                if (link.rsp_valid && link.rsp_op == RSP_OP_INV_START) begin
                    s_d.st    = C_DRAIN;
                    s_d.flush = 1'b1;
                end
            end
            C_DRAIN: begin
                // Ack queued behind any request still on the wire
                if (accesses_drained && !s_q.busy) begin
                    s_d.busy    = 1'b1;
                    s_d.beat    = 2'h0;
                    s_d.req_op  = REQ_OP_ACK;
                    s_d.st      = C_WAIT_END;
                end
            end
            C_WAIT_END: begin
                if (link.rsp_valid && link.rsp_op == RSP_OP_INV_END) begin
                    s_d.st      = C_RUN;
                    s_d.credits = 2'(CLIENT_CREDITS);
                end
            end
            default: s_d.st = C_RUN;
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            s_q         <= '0;
            s_q.credits <= 2'(CLIENT_CREDITS);
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    assign link.req_valid     = s_q.busy && s_q.beat == 2'h0;
    assign link.req_op        = s_q.req_op;
    assign link.req_client    = CLIENT_ID;
    assign link.req_wr        = s_q.req_wr;
    assign link.req_faultable = s_q.req_flt;
    assign link.req_track     = s_q.req_track;
    assign link.req_va        = s_q.req_va;

    assign tr_rsp_valid  = s_q.rsp_valid;
    assign tr_rsp_track  = s_q.rsp_track;
    assign tr_rsp_pa     = s_q.rsp_pa;
    assign tr_rsp_fault  = s_q.rsp_fault;
    assign tr_rsp_dirty  = s_q.rsp_dirty;
    assign tr_rsp_l3_ctl = s_q.rsp_l3;
    assign tlb_flush     = s_q.flush;
endmodule

// >>> test/walker_link_assertions.sv
// Checker: link protocol assertions between walker and client ends
`timescale 1ns/1ps
module walker_link_assertions
    import walker_link_pkg::*;
(
    input wire logic       clk_sys,
    input wire logic       reset_n,
    input wire logic       req_valid,
    input wire logic       req_op,
    input wire logic       rsp_valid,
    input wire logic [1:0] rsp_op,
    input wire logic [1:0] rsp_fault,
    input wire logic [2:0] rsp_mtype
);
    logic inv_on_q;
    logic ack_seen_q;
    wire  start_w = rsp_valid && rsp_op == RSP_OP_INV_START;
    wire  end_w   = rsp_valid && rsp_op == RSP_OP_INV_END;
    wire  ack_w   = req_valid && req_op == REQ_OP_ACK;

    // Tracks the open invalidation window and its acknowledge
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            inv_on_q   <= 1'h0;
            ack_seen_q <= 1'h0;
        end else begin
            if (start_w)
                inv_on_q <= 1'h1;
            else if (end_w)
                inv_on_q <= 1'h0;
            if (start_w)
                ack_seen_q <= 1'h0;
            else if (ack_w && inv_on_q)
                ack_seen_q <= 1'h1;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    rsp_spacing_a: assert property (
        rsp_valid |=> !rsp_valid [*3])
        else $error("response messages closer than four cycles");
    rsp_fields_hold_a: assert property (
        rsp_valid |=> ($stable(rsp_op) && $stable(rsp_fault)
                       && $stable(rsp_mtype)) [*3])
        else $error("response fields changed inside a message");
    rsp_op_legal_a: assert property (
        rsp_valid |-> rsp_op != RSP_OP_RESERVED)
        else $error("reserved response opcode sent");
    no_page_inv_a: assert property (
        rsp_valid && inv_on_q |-> rsp_op != RSP_OP_PAGE)
        else $error("page response inside invalidation");
    single_seq_a: assert property (
        start_w |-> !inv_on_q)
        else $error("second start before end");
    no_req_inv_a: assert property (
        req_valid && inv_on_q && $past(inv_on_q) |-> req_op == REQ_OP_ACK)
        else $error("page request inside invalidation");
    ack_in_seq_a: assert property (
        ack_w |-> inv_on_q)
        else $error("acknowledge outside invalidation");
    end_after_ack_a: assert property (
        end_w |-> ack_seen_q)
        else $error("end sent without acknowledge");
    end_bounded_a: assert property (
        ack_w && inv_on_q |-> ##[1:12] end_w)
        else $error("end not sent after acknowledge");
    req_spacing_a: assert property (
        req_valid |=> (!req_valid && $stable(req_op)) [*3])
        else $error("request message broken");

    start_c: cover property (start_w);
    end_c:   cover property (end_w);
    ack_c:   cover property (ack_w);
    page_c:  cover property (rsp_valid && rsp_op == RSP_OP_PAGE);
endmodule

// >>> test/tb_top.sv
// Testbench: walker end and one client end joined by the link
`timescale 1ns/1ps
module tb_top;
    import walker_link_pkg::*;
    logic             clk_sys, reset_n, inv_event, inv_busy, tlb_flush;
    logic             tr_req_valid, tr_req_ready, tr_req_wr;
    logic             tr_rsp_valid, tr_rsp_dirty, accesses_drained;
    logic [7:0]       tr_req_track, tr_rsp_track, walk_req_track;
    logic [7:0]       walk_rsp_track;
    logic [35:0]      tr_req_va, walk_req_va;
    logic [26:0]      tr_rsp_pa, walk_rsp_pa;
    logic [1:0]       tr_rsp_fault, tr_rsp_l3_ctl, walk_req_client;
    logic [1:0]       walk_rsp_fault, walk_rsp_client;
    logic             clk_en, tr_req_faultable, walk_req_faultable;
    logic             walk_rsp_dirty;
    logic             walk_req_valid, walk_req_wr, walk_rsp_valid;
    logic             walk_rsp_ready, walk_rsp_wr;
    logic [2:0]       walk_rsp_mtype;
    int               num_errors, num_checks, n_start, n_end, n_flush;
    logic [2:0]       mt_tab [6] = '{MTYPE_UC, MTYPE_WC, MTYPE_WT,
                                     MTYPE_WB, MTYPE_WP, MTYPE_WP};
    logic             wr_tab [6] = '{1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1};
    logic [1:0]       l3_tab [6] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3, 2'h1};

    walker_link_if link ();
    page_walker_end #(.N_CLIENTS(1)) u_page_walker_end (
        .clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en), .link(link),
        .walk_req_valid(walk_req_valid), .walk_req_client(walk_req_client),
        .walk_req_wr(walk_req_wr), .walk_req_faultable(walk_req_faultable),
        .walk_req_track(walk_req_track), .walk_req_va(walk_req_va),
        .walk_rsp_valid(walk_rsp_valid), .walk_rsp_ready(walk_rsp_ready),
        .walk_rsp_client(walk_rsp_client), .walk_rsp_wr(walk_rsp_wr),
        .walk_rsp_dirty(walk_rsp_dirty), .walk_rsp_fault(walk_rsp_fault),
        .walk_rsp_mtype(walk_rsp_mtype), .walk_rsp_track(walk_rsp_track),
        .walk_rsp_pa(walk_rsp_pa), .inv_event(inv_event),
        .inv_busy(inv_busy));
    data_port_client_end #(.CLIENT_ID(2'h0)) u_data_port_client_end (
        .clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en), .link(link),
        .tr_req_valid(tr_req_valid), .tr_req_ready(tr_req_ready),
        .tr_req_wr(tr_req_wr), .tr_req_faultable(tr_req_faultable),
        .tr_req_track(tr_req_track), .tr_req_va(tr_req_va),
        .tr_rsp_valid(tr_rsp_valid), .tr_rsp_track(tr_rsp_track),
        .tr_rsp_pa(tr_rsp_pa), .tr_rsp_fault(tr_rsp_fault),
        .tr_rsp_dirty(tr_rsp_dirty), .tr_rsp_l3_ctl(tr_rsp_l3_ctl),
        .tlb_flush(tlb_flush), .accesses_drained(accesses_drained));
    walker_link_assertions u_walker_link_assertions (
        .clk_sys(clk_sys), .reset_n(reset_n), .req_valid(link.req_valid),
        .req_op(link.req_op), .rsp_valid(link.rsp_valid),
        .rsp_op(link.rsp_op), .rsp_fault(link.rsp_fault),
        .rsp_mtype(link.rsp_mtype));

    initial begin
        clk_sys = 1'h0;
        forever #50 clk_sys = ~clk_sys;
    end

    // Counts invalidation start and end messages and wipes, pulses last a whole cycle
    always @(negedge clk_sys) begin
        if (link.rsp_valid === 1'h1 && link.rsp_op === RSP_OP_INV_START)
            n_start++;
        if (link.rsp_valid === 1'h1 && link.rsp_op === RSP_OP_INV_END)
            n_end++;
        if (tlb_flush === 1'h1)
            n_flush++;
    end

    function automatic bit cond(input int w);
        case (w)
            0: return tr_req_ready === 1'h1;
            1: return walk_req_valid === 1'h1;
            2: return tr_rsp_valid === 1'h1;
            3: return walk_rsp_ready === 1'h1;
            4: return tlb_flush === 1'h1;
            default: return inv_busy === 1'h0;
        endcase
    endfunction

    task automatic results();
        $display("errors %0d checks %0d", num_errors, num_checks);
        if (num_errors == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(input bit ok, input string msg);
        num_checks++;
        if (!ok) begin
            $display("MISMATCH %0t %s", $time, msg);
            num_errors++;
        end
    endtask

    task automatic wait_on(input int w);
        for (int i = 0; i < 80 && !cond(w); i++)
            @(negedge clk_sys);
        if (!cond(w)) begin
            $display("MISMATCH %0t wait %0d timed out", $time, w);
            num_errors++;
            results();
        end
    endtask

    task automatic tr_req(input logic wr, input logic [7:0] trk);
        wait_on(0);
        tr_req_valid = 1'h1;
        tr_req_wr = wr;
        tr_req_track = trk;
        tr_req_va = {28'h0abc123, trk};
        tr_req_faultable = trk[0];
        @(negedge clk_sys);
        tr_req_valid = 1'h0;
    endtask

    task automatic walk_rsp(input logic wr, input logic [7:0] trk,
                            input logic [1:0] flt, input logic [2:0] mt);
        wait_on(3);
        walk_rsp_valid = 1'h1;
        walk_rsp_wr = wr;
        walk_rsp_track = trk;
        walk_rsp_fault = flt;
        walk_rsp_mtype = mt;
        walk_rsp_pa = {19'h5a5a, trk};
        walk_rsp_dirty = ~wr;
        @(negedge clk_sys);
        walk_rsp_valid = 1'h0;
    endtask

    // One request through both ends and its answer back
    task automatic translate(input int i);
        logic [7:0] trk;
        trk = 8'h10 + 8'(i);
        tr_req(wr_tab[i], trk);
        wait_on(1);
        check(walk_req_track === trk && walk_req_wr === wr_tab[i]
              && walk_req_faultable === trk[0]
              && walk_req_client === 2'h0, "walk request");
        check(walk_req_va === {28'h0abc123, trk}, "walk address");
        walk_rsp(wr_tab[i], trk, 2'(i), mt_tab[i]);
        wait_on(2);
        check(tr_rsp_pa === {19'h5a5a, trk}, "response address");
        check(tr_rsp_track === trk && tr_rsp_dirty === ~wr_tab[i],
              "response track");
        check(tr_rsp_fault === 2'(i), "fault code");
        check(tr_rsp_l3_ctl === l3_tab[i], "level-3 control");
    endtask

    initial begin
        {reset_n, inv_event, tr_req_valid, tr_req_wr} = 4'h0;
        {walk_rsp_valid, walk_rsp_wr, walk_rsp_fault} = 4'h0;
        {tr_req_track, walk_rsp_track, walk_rsp_mtype} = 19'h0;
        tr_req_va = 36'h0;
        walk_rsp_pa = 27'h0;
        accesses_drained = 1'h1;
        clk_en = 1'h1;
        {tr_req_faultable, walk_rsp_dirty, walk_rsp_client} = 4'h0;
        {num_errors, num_checks, n_start, n_end, n_flush} = '0;
        repeat (2) @(negedge clk_sys);
        reset_n = 1'h1;
        // Frozen clock enable: an event must leave no trace
        clk_en = 1'h0;
        inv_event = 1'h1;
        @(negedge clk_sys);
        inv_event = 1'h0;
        clk_en = 1'h1;
        check(inv_busy === 1'h0, "frozen state");
        for (int i = 0; i < 6; i++)
            translate(i);
        // Both credits spent, then returned by two answers, the second sent once the response slot frees
        tr_req(1'h0, 8'h20);
        tr_req(1'h0, 8'h21);
        repeat (10) @(negedge clk_sys);
        check(tr_req_ready === 1'h0, "credit limit");
        walk_rsp_client = 2'h1;
        walk_rsp(1'h0, 8'h20, FAULT_NONE, MTYPE_WB);
        walk_rsp_client = 2'h0;
        repeat (8) @(negedge clk_sys);
        check(tr_req_ready === 1'h0, "foreign answer");
        walk_rsp(1'h0, 8'h20, FAULT_NONE, MTYPE_WB);
        walk_rsp(1'h0, 8'h21, FAULT_NONE, MTYPE_WB);
        wait_on(0);
        check(tr_req_ready === 1'h1, "credit returned");
        // Invalidation with drain held off, second event mid-sequence
        accesses_drained = 1'h0;
        inv_event = 1'h1;
        @(negedge clk_sys);
        inv_event = 1'h0;
        wait_on(4);
        walk_rsp_valid = 1'h1;
        @(negedge clk_sys);
        check(walk_rsp_ready === 1'h0, "walker open");
        check(tr_req_ready === 1'h0 && inv_busy === 1'h1, "client open");
        walk_rsp_valid = 1'h0;
        inv_event = 1'h1;
        @(negedge clk_sys);
        inv_event = 1'h0;
        repeat (20) @(negedge clk_sys);
        check(n_end === 0 && n_start === 1, "early end");
        accesses_drained = 1'h1;
        wait_on(5);
        @(negedge clk_sys);
        check(n_start === 2 && n_end === 2, "sequence count");
        check(n_flush === 2, "wipe count");
        translate(3);
        // Reset in mid-message must leave both ends idle
        reset_n = 1'h0;
        @(negedge clk_sys);
        check(tr_req_ready === 1'h1 && walk_rsp_ready === 1'h1
              && inv_busy === 1'h0 && tr_rsp_valid === 1'h0,
              "reset state");
        reset_n = 1'h1;
        translate(2);
        results();
    end
endmodule
